/* File: hdl/tofcs_pkg.sv */
// register map and field layout for the echo configuration and status bank
package tofcs_pkg;
   // register offsets
   localparam logic [3:0] OFS_ECHO_TX_CTRL      = 4'h4;
   localparam logic [3:0] OFS_RECEIVE_GAIN_CTRL = 4'h5;
   localparam logic [3:0] OFS_WINDOW_DELAY_LOW  = 4'h6;
   localparam logic [3:0] OFS_FAULT_FLAGS       = 4'h7;
   localparam logic [3:0] OFS_TIMEOUT_CTRL      = 4'h8;
   localparam logic [3:0] OFS_CLOCK_RATE        = 4'h9;
   // reset values
   localparam logic [7:0] RST_ECHO_TX_CTRL      = 8'h1F;
   localparam logic [7:0] RST_RECEIVE_GAIN_CTRL = 8'h00;
   localparam logic [7:0] RST_WINDOW_DELAY_LOW  = 8'h00;
   localparam logic [7:0] RST_TIMEOUT_CTRL      = 8'h19;
   localparam logic [7:0] RST_CLOCK_RATE        = 8'h00;
   // echo_tx_ctrl fields
   localparam int MULTI_ECHO_BIT   = 6;
   localparam int TRIG_EDGE_BIT    = 5;
   localparam int BURST_POS_MSB    = 4;
   // receive_gain_ctrl fields
   localparam int GAIN_MSB         = 7;
   localparam int GAIN_LSB         = 5;
   localparam int GAIN_BYPASS_BIT  = 4;
   localparam int LNA_BYPASS_BIT   = 3;
   localparam int LOW_NOISE_AMP_FEEDBACK_BIT       = 2;
   localparam int DELAY_HI_MSB     = 1;
   // fault_flags fields
   localparam int WEAK_BIT         = 2;
   localparam int NO_ECHO_BIT      = 1;
   localparam int OVERRANGE_BIT    = 0;
   // timeout_ctrl fields
   localparam int SHORT_FORCE_BIT  = 6;
   localparam int BLANK_MSB        = 5;
   localparam int BLANK_LSB        = 3;
   localparam int TIMEOUT_DIS_BIT  = 2;
   localparam int WINDOW_MSB       = 1;
   // clock rate field
   localparam int HALVER_BIT       = 2;
   // echo threshold code that enables overrange reporting
   localparam logic [2:0] THRESH_MAX = 3'h7;
   // zero events code means 32 stop pulses
   localparam logic [5:0] STOP_ALL  = 6'h20;
endpackage : tofcs_pkg

/* File: hdl/tofcs_regs.sv */
// echo configuration and status register bank with fault flags
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tofcs_regs
   import tofcs_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   input  wire logic [2:0] rx_event_code_in,
   input  wire logic [2:0] echo_threshold_code_in,
   input  wire logic       echo_timeout_in,
   input  wire logic       echo_seen_in,
   input  wire logic [5:0] crossing_count_in,
   input  wire logic       overrange_in,
   output logic            multi_echo_out,
   output logic            trigger_edge_select_out,
   output logic      [4:0] burst_invert_position_out,
   output logic      [2:0] amp_gain_code_out,
   output logic      [4:0] amp_gain_db_out,
   output logic            gain_amp_bypass_out,
   output logic            low_noise_amp_bypass_out,
   output logic            low_noise_amp_feedback_out,
   output logic      [9:0] window_delay_out,
   output logic            short_flight_force_out,
   output logic      [2:0] short_flight_blank_len_out,
   output logic     [10:0] blank_periods_out,
   output logic            echo_timeout_disable_out,
   output logic      [1:0] listen_window_len_out,
   output logic     [10:0] window_periods_out,
   output logic      [5:0] stop_pulse_count_out,
   output logic            input_clock_halver_out,
   output logic            base_tick_out,
   output logic            meas_reset_out,
   output logic            weak_echo_flag_out,
   output logic            no_echo_flag_out,
   output logic            echo_overrange_flag_out,
   output logic            fault_out_n
);
   logic [7:0] echo_tx_ff;
   logic [7:0] gain_ff;
   logic [7:0] delay_lo_ff;
   logic [7:0] timeout_ff;
   logic [7:0] clk_rate_ff;
   logic [2:0] flags_ff;
   logic [2:0] nxt_flags;
   logic [2:0] ev_s1_ff;
   logic [2:0] ev_s2_ff;
   logic [2:0] prev_ev_ff;
   logic [2:0] rx_s1_ff;
   logic [2:0] rx_s2_ff;
   logic [2:0] th_s1_ff;
   logic [2:0] th_s2_ff;
   logic [5:0] cc_s1_ff;
   logic [5:0] cc_s2_ff;
   logic       base_div_ff;
   logic       wr_flags;
   logic       timeout_rise;
   logic       seen_rise;
   logic       over_rise;

   // periods are eight or 128 base periods shifted by a code
   function automatic logic [10:0] periods(input logic [10:0] base_val, input logic [2:0] code);
      periods = base_val << code;
   endfunction

   function automatic logic wr_hit(input logic [3:0] ofs);
      wr_hit = wr_in && (addr_in == ofs);
   endfunction

   // configuration registers, every bit of the written byte stored
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         echo_tx_ff  <= RST_ECHO_TX_CTRL;
         gain_ff     <= RST_RECEIVE_GAIN_CTRL;
         delay_lo_ff <= RST_WINDOW_DELAY_LOW;
         timeout_ff  <= RST_TIMEOUT_CTRL;
         clk_rate_ff <= RST_CLOCK_RATE;
      end else begin
         if (wr_hit(OFS_ECHO_TX_CTRL)) begin
            echo_tx_ff <= wdata_in;
         end
         if (wr_hit(OFS_RECEIVE_GAIN_CTRL)) begin
            gain_ff <= wdata_in;
         end
         if (wr_hit(OFS_WINDOW_DELAY_LOW)) begin
            delay_lo_ff <= wdata_in;
         end
         if (wr_hit(OFS_TIMEOUT_CTRL)) begin
            timeout_ff <= wdata_in;
         end
         if (wr_hit(OFS_CLOCK_RATE)) begin
            clk_rate_ff <= wdata_in;
         end
      end
   end

   // two-stage synchronisers for measurement-side inputs
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ev_s1_ff   <= 3'h0;
         ev_s2_ff   <= 3'h0;
         prev_ev_ff <= 3'h0;
         rx_s1_ff   <= 3'h0;
         rx_s2_ff   <= 3'h0;
         th_s1_ff   <= 3'h0;
         th_s2_ff   <= 3'h0;
         cc_s1_ff   <= 6'h00;
         cc_s2_ff   <= 6'h00;
      end else begin
         ev_s1_ff   <= {overrange_in, echo_seen_in, echo_timeout_in};
         ev_s2_ff   <= ev_s1_ff;
         prev_ev_ff <= ev_s2_ff;
         rx_s1_ff   <= rx_event_code_in;
         rx_s2_ff   <= rx_s1_ff;
         th_s1_ff   <= echo_threshold_code_in;
         th_s2_ff   <= th_s1_ff;
         cc_s1_ff   <= crossing_count_in;
         cc_s2_ff   <= cc_s1_ff;
      end
   end

   assign timeout_rise = ev_s2_ff[0] && !prev_ev_ff[0];
   assign seen_rise    = ev_s2_ff[1] && !prev_ev_ff[1];
   assign over_rise    = ev_s2_ff[2] && !prev_ev_ff[2];
   assign wr_flags     = wr_hit(OFS_FAULT_FLAGS);

   // sticky fault flags, a new event wins over a clear
   always_comb begin
      nxt_flags = flags_ff;
      if (wr_flags && wdata_in[OVERRANGE_BIT]) begin
         nxt_flags = 3'h0;
      end
      if (timeout_rise && !timeout_ff[TIMEOUT_DIS_BIT]) begin
         if (!ev_s2_ff[1] && !seen_rise) begin
            nxt_flags[NO_ECHO_BIT] = 1'b1;
         end else if ({3'h0, cc_s2_ff} < {3'h0, stop_count(rx_s2_ff)}) begin
            nxt_flags[WEAK_BIT] = 1'b1;
         end
      end
      if (over_rise && (th_s2_ff == THRESH_MAX)) begin
         nxt_flags[OVERRANGE_BIT] = 1'b1;
      end
   end

   // zero-bit writes leave flags alone
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags_ff <= 3'h0;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // expected stop pulses for an event code
   function automatic logic [5:0] stop_count(input logic [2:0] code);
      stop_count = (code == 3'h0) ? STOP_ALL : {3'h0, code};
   endfunction

   // measurement reset pulse on write one to no-echo bit
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meas_reset_out <= 1'b0;
      end else begin
         meas_reset_out <= wr_flags && wdata_in[NO_ECHO_BIT];
      end
   end

   // base period tick, every clock or every second clock
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         base_div_ff   <= 1'b0;
         base_tick_out <= 1'b0;
      end else begin
         base_div_ff   <= clk_rate_ff[HALVER_BIT] ? !base_div_ff : 1'b0;
         base_tick_out <= !clk_rate_ff[HALVER_BIT] || base_div_ff;
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         unique case (addr_in)
            OFS_ECHO_TX_CTRL:      rdata_out <= echo_tx_ff;
            OFS_RECEIVE_GAIN_CTRL: rdata_out <= gain_ff;
            OFS_WINDOW_DELAY_LOW:  rdata_out <= delay_lo_ff;
            OFS_FAULT_FLAGS:       rdata_out <= {5'h00, flags_ff};
            OFS_TIMEOUT_CTRL:      rdata_out <= timeout_ff;
            OFS_CLOCK_RATE:        rdata_out <= clk_rate_ff;
            default:               rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // decoded configuration outputs, registered
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         multi_echo_out             <= 1'b0;
         trigger_edge_select_out    <= 1'b0;
         burst_invert_position_out  <= 5'h1F;
         amp_gain_code_out          <= 3'h0;
         amp_gain_db_out            <= 5'h00;
         gain_amp_bypass_out        <= 1'b0;
         low_noise_amp_bypass_out   <= 1'b0;
         low_noise_amp_feedback_out <= 1'b0;
         window_delay_out           <= 10'h000;
         short_flight_force_out     <= 1'b0;
         short_flight_blank_len_out <= 3'h3;
         blank_periods_out          <= 11'h040;
         echo_timeout_disable_out   <= 1'b0;
         listen_window_len_out      <= 2'h1;
         window_periods_out         <= 11'h100;
         stop_pulse_count_out       <= STOP_ALL;
         input_clock_halver_out     <= 1'b0;
      end else begin
         multi_echo_out             <= echo_tx_ff[MULTI_ECHO_BIT];
         trigger_edge_select_out    <= echo_tx_ff[TRIG_EDGE_BIT];
         burst_invert_position_out  <= echo_tx_ff[BURST_POS_MSB:0];
         amp_gain_code_out          <= gain_ff[GAIN_MSB:GAIN_LSB];
         amp_gain_db_out            <= {2'h0, gain_ff[GAIN_MSB:GAIN_LSB]} * 5'h03;
         gain_amp_bypass_out        <= gain_ff[GAIN_BYPASS_BIT];
         low_noise_amp_bypass_out   <= gain_ff[LNA_BYPASS_BIT];
         low_noise_amp_feedback_out <= gain_ff[LOW_NOISE_AMP_FEEDBACK_BIT];
         window_delay_out           <= {gain_ff[DELAY_HI_MSB:0], delay_lo_ff};
         short_flight_force_out     <= timeout_ff[SHORT_FORCE_BIT];
         short_flight_blank_len_out <= timeout_ff[BLANK_MSB:BLANK_LSB];
         blank_periods_out          <= periods(11'h008, timeout_ff[BLANK_MSB:BLANK_LSB]);
         echo_timeout_disable_out   <= timeout_ff[TIMEOUT_DIS_BIT];
         listen_window_len_out      <= timeout_ff[WINDOW_MSB:0];
         window_periods_out         <= periods(11'h080, {1'b0, timeout_ff[WINDOW_MSB:0]});
         stop_pulse_count_out       <= stop_count(rx_s2_ff);
         input_clock_halver_out     <= clk_rate_ff[HALVER_BIT];
      end
   end

   // flag outputs and active-low fault pin
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         weak_echo_flag_out      <= 1'b0;
         no_echo_flag_out        <= 1'b0;
         echo_overrange_flag_out <= 1'b0;
         fault_out_n             <= 1'b1;
      end else begin
         weak_echo_flag_out      <= nxt_flags[WEAK_BIT];
         no_echo_flag_out        <= nxt_flags[NO_ECHO_BIT];
         echo_overrange_flag_out <= nxt_flags[OVERRANGE_BIT];
         fault_out_n             <= ~|nxt_flags;
      end
   end
endmodule : tofcs_regs
`default_nettype wire

/* File: sim/tofcs_regs_sva.sv */
// concurrent checks for the echo configuration and status bank
`timescale 1ns/1ps
`default_nettype none
module tofcs_regs_chk
   import tofcs_pkg::*;
(
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire logic  [3:0] addr_in,
   input wire logic  [7:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic  [7:0] rdata_out,
   input wire logic  [2:0] echo_threshold_code_in,
   input wire logic        echo_timeout_in,
   input wire logic        overrange_in,
   input wire logic        multi_echo_out,
   input wire logic  [1:0] listen_window_len_out,
   input wire logic [10:0] window_periods_out,
   input wire logic        meas_reset_out,
   input wire logic        weak_echo_flag_out,
   input wire logic        no_echo_flag_out,
   input wire logic        echo_overrange_flag_out,
   input wire logic        fault_out_n
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [2:0] flg;
   logic       clr;
   logic       stp;
   logic [3:0] evh;
   // flag vector and fault write strobes
   assign flg = {weak_echo_flag_out, no_echo_flag_out, echo_overrange_flag_out};
   assign clr = wr_in && addr_in == OFS_FAULT_FLAGS && wdata_in[OVERRANGE_BIT];
   assign stp = wr_in && addr_in == OFS_FAULT_FLAGS && wdata_in[NO_ECHO_BIT];
   // event input history, all zero means no rise is in flight
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) evh <= 4'hF;
      else evh <= {evh[2:0], echo_timeout_in | overrange_in};
   end
   sequence s_tx_wr;
      wr_in && addr_in == OFS_ECHO_TX_CTRL ##1 !(wr_in && addr_in == OFS_ECHO_TX_CTRL);
   endsequence
   sequence s_quiet_clr;
      clr && evh == 4'h0 && !(echo_timeout_in | overrange_in);
   endsequence
   chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data not zero outside read answer");
   chk_multi_echo: assert property (s_tx_wr |-> ##1 multi_echo_out == $past(wdata_in[MULTI_ECHO_BIT], 2))
      else $error("echo mode output does not follow write");
   chk_window_len: assert property (window_periods_out == (11'h080 << listen_window_len_out))
      else $error("listen window length decode wrong");
   chk_meas_pulse: assert property (stp |=> meas_reset_out)
      else $error("measurement reset pulse missing");
   chk_meas_cause: assert property (meas_reset_out |-> $past(stp))
      else $error("measurement reset pulse without write");
   chk_clear_all: assert property (s_quiet_clr |=> flg == 3'h0)
      else $error("fault flags not cleared");
   chk_flag_sticky: assert property ((|($past(flg) & ~flg)) |-> $past(clr))
      else $error("fault flag fell without clear write");
   chk_fault_pin: assert property (flg == $past(flg) |-> fault_out_n == (flg == 3'h0))
      else $error("fault pin disagrees with flags");
   chk_over_thr: assert property ($rose(echo_overrange_flag_out) |-> $past(echo_threshold_code_in, 3) == THRESH_MAX)
      else $error("overrange flag with threshold below max");
   chk_no_echo: assert property ($rose(no_echo_flag_out)
      |-> $past(echo_timeout_in, 2) || $past(echo_timeout_in, 3) || $past(echo_timeout_in, 4))
      else $error("no echo flag without timeout");
endmodule // tofcs_regs_chk
bind tofcs_regs tofcs_regs_chk chk_u (.ref_clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
   .echo_threshold_code_in, .echo_timeout_in, .overrange_in, .multi_echo_out, .listen_window_len_out,
   .window_periods_out, .meas_reset_out, .weak_echo_flag_out, .no_echo_flag_out, .echo_overrange_flag_out,
   .fault_out_n);
`default_nettype wire

/* File: sim/tofcs_regs_tb_top.sv */
// self-checking bench for the echo configuration and status bank
`timescale 1ns/1ps
`default_nettype none
module tofcs_regs_tb_top
   import tofcs_pkg::*;
();
   logic        ref_clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, mr;
   logic        echo_timeout_in = 1'b0, echo_seen_in = 1'b0, overrange_in = 1'b0;
   logic  [2:0] rx_event_code_in = 3'h0, echo_threshold_code_in = 3'h0, gain, blank;
   logic  [3:0] addr_in = 4'h0, a;
   logic  [7:0] d;
   logic  [5:0] crossing_count_in = 6'h00, stops;
   logic  [7:0] wdata_in = 8'h00, rdata_out;
   logic        multi, trig, gbyp, lbyp, lfb, sforce, tdis, halver, tick, mres, wk, ne, ovf, fault_out_n;
   logic  [4:0] burst, gdb;
   logic  [1:0] win;
   logic  [9:0] delay;
   logic [10:0] bper, wper;
   logic  [7:0] m [16];
   logic  [3:0] addrs [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hF};
   int          fails = 0, checked = 0, cyc = 0, n, h;
   tofcs_regs dut_u (.ref_clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .rx_event_code_in,
      .echo_threshold_code_in, .echo_timeout_in, .echo_seen_in, .crossing_count_in, .overrange_in,
      .multi_echo_out(multi), .trigger_edge_select_out(trig), .burst_invert_position_out(burst),
      .amp_gain_code_out(gain), .amp_gain_db_out(gdb), .gain_amp_bypass_out(gbyp), .low_noise_amp_bypass_out(lbyp),
      .low_noise_amp_feedback_out(lfb), .window_delay_out(delay), .short_flight_force_out(sforce),
      .short_flight_blank_len_out(blank), .blank_periods_out(bper), .echo_timeout_disable_out(tdis),
      .listen_window_len_out(win), .window_periods_out(wper), .stop_pulse_count_out(stops),
      .input_clock_halver_out(halver), .base_tick_out(tick), .meas_reset_out(mres), .weak_echo_flag_out(wk),
      .no_echo_flag_out(ne), .echo_overrange_flag_out(ovf), .fault_out_n);
   // clock and hang guard
   always #10 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         results();
      end
   end
   task automatic results;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp_rd(input string nm, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e) begin
         fails++;
         $display("BAD %s exp %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic cmp_out(input string nm, input logic [10:0] e, input logic [10:0] s);
      checked++;
      if (s !== e) begin
         fails++;
         $display("BAD %s exp %0h seen %0h", nm, e, s);
      end
   endtask
   // reset with model back to table values
   task automatic do_rst;
      rst_n_in <= 1'b0;
      foreach (m[i]) m[i] = 8'h00;
      m[4] = 8'h1F;
      m[8] = 8'h19;
      repeat (12) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      @(posedge ref_clk_in);
   endtask
   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      addr_in  <= ad;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge ref_clk_in);
      wr_in    <= 1'b0;
      if (ad inside {4'h4, 4'h5, 4'h6, 4'h8, 4'h9}) m[ad] = d;
      #1 mr = mres;
      @(posedge ref_clk_in);
   endtask
   task automatic rd(input logic [3:0] ad, input logic [7:0] e);
      addr_in <= ad;
      rd_in   <= 1'b1;
      @(posedge ref_clk_in);
      rd_in   <= 1'b0;
      #1 cmp_rd("rdata", e, rdata_out);
      @(posedge ref_clk_in);
   endtask
   // raise timeout or overrange level, then drop it
   task automatic ev(input logic t);
      if (t) echo_timeout_in <= 1'b1;
      else overrange_in <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
      echo_timeout_in <= 1'b0;
      overrange_in    <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
   endtask
   task automatic chk_cfg;
      #1 cmp_out("echo_tx", 11'(m[4][6:0]), 11'({multi, trig, burst}));
      cmp_out("gain", 11'(m[5][7:2]), 11'({gain, gbyp, lbyp, lfb}));
      cmp_out("gain_db", 11'(m[5][7:5] * 3), 11'(gdb));
      cmp_out("delay", 11'({m[5][1:0], m[6]}), 11'(delay));
      cmp_out("timeout", 11'(m[8][6:0]), 11'({sforce, blank, tdis, win}));
      cmp_out("blank", 11'(8 << m[8][5:3]), bper);
      cmp_out("window", 11'(128 << m[8][1:0]), wper);
      cmp_out("halver", 11'(m[9][2]), 11'(halver));
   endtask
   // main sequence
   initial begin
      void'($urandom(57));
      do_rst();
      for (n = 0; n < 16; n++) rd(4'(n), m[n]);
      chk_cfg();
      for (n = 0; n < 8; n++) begin
         rx_event_code_in <= 3'(n);
         repeat (4) @(posedge ref_clk_in);
         #1 cmp_out("stops", 11'((n == 0) ? 32 : n), 11'(stops));
      end
      for (n = 0; n < 24; n++) begin
         a = addrs[$urandom % 8];
         d = 8'($urandom);
         if (a == OFS_ECHO_TX_CTRL && d[4:1] == 4'h0) d[1] = 1'b1;
         wr(a, d);
         chk_cfg();
         rd(a, m[a]);
      end
      for (h = 0; h < 2; h++) begin
         wr(OFS_CLOCK_RATE, h ? 8'h04 : 8'h00);
         n = 0;
         repeat (8) begin
            @(posedge ref_clk_in);
            #1 n += int'(tick);
         end
         cmp_out("tick", 11'(h ? 4 : 8), 11'(n));
      end
      do_rst();
      rd(OFS_ECHO_TX_CTRL, 8'h1F);
      echo_threshold_code_in <= 3'h3;
      ev(1'b0);
      rd(OFS_FAULT_FLAGS, 8'h00);
      echo_threshold_code_in <= THRESH_MAX;
      repeat (4) @(posedge ref_clk_in);
      ev(1'b0);
      rd(OFS_FAULT_FLAGS, 8'h01);
      cmp_out("fault_n", 11'h000, 11'(fault_out_n));
      wr(OFS_FAULT_FLAGS, 8'h00);
      rd(OFS_FAULT_FLAGS, 8'h01);
      ev(1'b1);
      rd(OFS_FAULT_FLAGS, 8'h03);
      wr(OFS_FAULT_FLAGS, 8'h02);
      cmp_out("meas_reset", 11'h001, 11'(mr));
      rd(OFS_FAULT_FLAGS, 8'h03);
      wr(OFS_FAULT_FLAGS, 8'h01);
      rd(OFS_FAULT_FLAGS, 8'h00);
      cmp_out("fault_n", 11'h001, 11'(fault_out_n));
      rx_event_code_in  <= 3'h3;
      crossing_count_in <= 6'h02;
      echo_seen_in      <= 1'b1;
      ev(1'b1);
      rd(OFS_FAULT_FLAGS, 8'h04);
      wr(OFS_FAULT_FLAGS, 8'h01);
      echo_seen_in <= 1'b0;
      wr(OFS_TIMEOUT_CTRL, 8'h1D);
      ev(1'b1);
      rd(OFS_FAULT_FLAGS, 8'h00);
      results();
   end
endmodule // tofcs_regs_tb_top
`default_nettype wire
